// *** verilog/engine_start_defs.svh ***
// constants for the engine start sequencer: timing, reset values, defaults
// assumes a 125 MHz ref_clk; all setpoint times are in 0.1 s ticks
`ifndef ENGINE_START_DEFS_SVH
`define ENGINE_START_DEFS_SVH

// ==================================================================
// timing
`define CLK_PERIOD_PS   8000
`define TICK_PERIOD_MS  100
// split so the product stays inside 32-bit integer range
`define TICK_CYCLES     ((`TICK_PERIOD_MS * 1000000) / (`CLK_PERIOD_PS / 1000))

// ==================================================================
// field widths
`define TIME_W          14
`define RPM_W           13
`define REPEAT_W        5
`define ACTION_W        3
`define SCALED_W        17

// ==================================================================
// idle detection at 90 percent: speed * 10 >= idle * 9
`define IDLE_NUM        17'h00009
`define IDLE_DEN        17'h0000A

// ==================================================================
// setpoint defaults, times in tenths of a second
`define DEF_HEATER      14'h0000
`define DEF_FUEL_LAG    14'h0002
`define DEF_CRANK       14'h0064
`define DEF_CUTOUT      13'h0226
`define DEF_RETRY       14'h012C
`define DEF_REPEATS     5'h03
`define DEF_ACTION      3'h5
`define DEF_NO_SPEED    14'h001E
`define DEF_IDLE_RPM    13'h04B0
`define DEF_IDLE_TIME   14'h00C8

// ==================================================================
// reset values
`define RST_TIME        14'h0000
`define RST_ATTEMPTS    5'h00
`define RST_ACTION      3'h0

`endif

// *** verilog/engine_start_pkg.sv ***
// types shared by the engine start sequencer
// assumes engine_start_defs.svh is on the include path
`include "engine_start_defs.svh"

package engine_start_pkg;

  typedef enum logic [7:0] {
    ST_STOPPED = 8'h01,
    ST_PREHEAT = 8'h02,
    ST_CRANK   = 8'h04,
    ST_REST    = 8'h08,
    ST_SPINUP  = 8'h10,
    ST_IDLE    = 8'h20,
    ST_RATED   = 8'h40,
    ST_FAILED  = 8'h80
  } seq_state_t;

  typedef struct packed {
    logic                   seq_enable;
    logic [`TIME_W-1:0]     heater_plug_duration;
    logic [`TIME_W-1:0]     fuel_valve_lag;
    logic [`TIME_W-1:0]     crank_time;
    logic [`RPM_W-1:0]      cutout_rpm;
    logic [`TIME_W-1:0]     retry_time;
    logic [`REPEAT_W-1:0]   crank_repeats;
    logic [`ACTION_W-1:0]   fail_action;
    logic [`TIME_W-1:0]     no_speed_time;
    logic [`RPM_W-1:0]      idle_rpm;
    logic [`TIME_W-1:0]     idle_time;
  } settings_t;

  typedef struct packed {
    logic                   glow_plug;
    logic                   crank;
    logic                   fuel;
    logic                   rated;
    logic                   crank_fail;
    logic [`ACTION_W-1:0]   fail_action;
  } relays_t;

endpackage

// *** verilog/tick_divider.sv ***
// divides ref_clk into a one-cycle timebase strobe
// assumes a single synchronous clock domain
`timescale 1ns/1ps
`include "engine_start_defs.svh"

module tick_divider #(
  parameter int DIV = `TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      tick
);

  if (DIV < 2) begin : gen_div_check
    $error("tick_divider: DIV must be at least 2");
  end

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb begin
    tick_next  = (count_reg == 32'(DIV - 1));
    count_next = tick_next ? 32'h00000000 : count_reg + 32'h00000001;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg <= 32'h00000000;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// *** verilog/engine_start_sequencer.sv ***
// engine start sequencer: preheat, crank, fuel, retry, idle hold, rated
// assumes engine_rpm and settings come from logic on ref_clk; start pins are async
`timescale 1ns/1ps
`include "engine_start_defs.svh"

// Overview of operation
// (R1) preheat glow plug before each crank when sequencing
// (R2) glow plug held until starter released
// (R3) no glow plug with sequencing disabled
// (R4) fuel relay follows crank after programmed lag
// (R5) crank time limit releases starter, uses attempt
// (R6) sequencing disabled: starter never energized
// (R7) starter released at cutout speed
// (R8) wait retry interval between attempts
// (R9) attempts allowed equal repeats plus one; at repeats 31 the 5-bit sum wraps to 0 and only one attempt is allowed
// (R10) attempts exhausted: raise configured fail action
// (R11) no speed signal in wait: abort crank
// (R12) idle reached at 90 percent of setpoint
// (R13) hold idle time, then energize rated relay
// (R14) idle timer starts only after 90 percent
// (R15) sequencing disabled: rated relay on at start
// (R16) setpoints taken live without restart
// (R17) 0.1 s tick timers; reset stops all
// (R18) attempt count cleared on accepted start
module engine_start_sequencer #(
  parameter int TICK_DIV = `TICK_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        start_cmd,
  input  wire logic                        speed_detect,
  input  wire logic [`RPM_W-1:0]           engine_rpm,
  input  wire engine_start_pkg::settings_t settings,
  output engine_start_pkg::relays_t        relays,
  output engine_start_pkg::seq_state_t     seq_state,
  output logic [`REPEAT_W-1:0]             attempts_used
);

  if (TICK_DIV < 2) begin : gen_div_check
    $error("engine_start_sequencer: TICK_DIV must be at least 2");
  end

  // ==================================================================
  // input synchronisers
  logic run_meta_reg;
  logic run_reg;
  logic spd_meta_reg;
  logic spd_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_meta_reg <= 1'b0;
      run_reg      <= 1'b0;
      spd_meta_reg <= 1'b0;
      spd_reg      <= 1'b0;
    end else begin
      run_meta_reg <= start_cmd;
      run_reg      <= run_meta_reg;
      spd_meta_reg <= speed_detect;
      spd_reg      <= spd_meta_reg;
    end
  end

  // ==================================================================
  // timebase
  logic tick;

  tick_divider #(
    .DIV (TICK_DIV)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  // ==================================================================
  // speed comparisons, always against live setpoints
  logic [`SCALED_W-1:0] speed_scaled;
  logic [`SCALED_W-1:0] idle_scaled;
  logic                 at_idle;
  logic                 at_cutout;

  always_comb begin
    speed_scaled = `SCALED_W'(engine_rpm) * `IDLE_DEN;
    idle_scaled  = `SCALED_W'(settings.idle_rpm) * `IDLE_NUM;
    at_idle      = (speed_scaled >= idle_scaled); // R12 R16
    at_cutout    = (engine_rpm >= settings.cutout_rpm);
  end

  // ==================================================================
  // sequence state
  engine_start_pkg::seq_state_t state_reg;
  engine_start_pkg::seq_state_t state_next;
  logic [`TIME_W-1:0]           elapsed_reg;
  logic [`TIME_W-1:0]           elapsed_next;
  logic [`REPEAT_W-1:0]         attempts_reg;
  logic [`REPEAT_W-1:0]         attempts_next;
  logic [`REPEAT_W-1:0]         attempts_allowed;
  logic                         attempt_over;

  always_comb begin
    state_next       = state_reg;
    attempts_next    = attempts_reg;
    attempts_allowed = settings.crank_repeats + `REPEAT_W'(1); // R9
    attempt_over     = 1'b0;
    case (state_reg)
      engine_start_pkg::ST_STOPPED: begin
        if (run_reg) begin
          attempts_next = `RST_ATTEMPTS; // R18
          if (settings.seq_enable) begin
            state_next = engine_start_pkg::ST_PREHEAT; // R1
          end else begin
            state_next = engine_start_pkg::ST_RATED; // R15
          end
        end
      end
      engine_start_pkg::ST_PREHEAT: begin
        if (elapsed_reg >= settings.heater_plug_duration) begin
          state_next = engine_start_pkg::ST_CRANK; // R1
        end
      end
      engine_start_pkg::ST_CRANK: begin
        if (at_cutout) begin
          state_next = engine_start_pkg::ST_SPINUP; // R7
        end else if (elapsed_reg >= settings.crank_time) begin
          attempt_over = 1'b1; // R5
        end else if (!spd_reg && elapsed_reg >= settings.no_speed_time) begin
          attempt_over = 1'b1; // R11
        end
        if (attempt_over) begin
          attempts_next = attempts_reg + `REPEAT_W'(1);
          if (attempts_next >= attempts_allowed) begin
            state_next = engine_start_pkg::ST_FAILED; // R10
          end else begin
            state_next = engine_start_pkg::ST_REST;
          end
        end
      end
      engine_start_pkg::ST_REST: begin
        if (elapsed_reg >= settings.retry_time) begin
          state_next = engine_start_pkg::ST_PREHEAT; // R8
        end
      end
      engine_start_pkg::ST_SPINUP: begin
        if (at_idle) begin
          state_next = engine_start_pkg::ST_IDLE; // R14
        end
      end
      engine_start_pkg::ST_IDLE: begin
        if (elapsed_reg >= settings.idle_time) begin
          state_next = engine_start_pkg::ST_RATED; // R13
        end
      end
      engine_start_pkg::ST_RATED: begin
        state_next = state_reg;
      end
      engine_start_pkg::ST_FAILED: begin
        state_next = state_reg;
      end
      default: begin
        state_next = engine_start_pkg::ST_STOPPED;
      end
    endcase
    if (!run_reg) begin
      state_next = engine_start_pkg::ST_STOPPED;
    end
    // timer restarts on every state change, saturates otherwise
    if (state_next != state_reg) begin
      elapsed_next = `RST_TIME;
    end else if (tick && elapsed_reg != {`TIME_W{1'b1}}) begin
      elapsed_next = elapsed_reg + `TIME_W'(1); // R17
    end else begin
      elapsed_next = elapsed_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg    <= engine_start_pkg::ST_STOPPED; // R17
      elapsed_reg  <= `RST_TIME;
      attempts_reg <= `RST_ATTEMPTS;
    end else begin
      state_reg    <= state_next;
      elapsed_reg  <= elapsed_next;
      attempts_reg <= attempts_next;
    end
  end

  // ==================================================================
  // relay outputs, registered from the next state
  engine_start_pkg::relays_t relays_reg;
  engine_start_pkg::relays_t relays_next;

  always_comb begin
    relays_next = '0;
    // glow only exists in sequenced states, so never without sequencing
    relays_next.glow_plug = (state_next == engine_start_pkg::ST_PREHEAT) ||
                            (state_next == engine_start_pkg::ST_CRANK); // R2 R3
    relays_next.crank = (state_next == engine_start_pkg::ST_CRANK); // R6
    relays_next.fuel  = ((state_next == engine_start_pkg::ST_CRANK) &&
                         (elapsed_next >= settings.fuel_valve_lag)) ||
                        (state_next == engine_start_pkg::ST_SPINUP) ||
                        (state_next == engine_start_pkg::ST_IDLE) ||
                        (state_next == engine_start_pkg::ST_RATED); // R4
    relays_next.rated = (state_next == engine_start_pkg::ST_RATED); // R13 R15
    relays_next.crank_fail = (state_next == engine_start_pkg::ST_FAILED);
    relays_next.fail_action = relays_next.crank_fail ? settings.fail_action
                                                     : `RST_ACTION; // R10
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      relays_reg <= '0; // R17
    end else begin
      relays_reg <= relays_next;
    end
  end

  assign relays        = relays_reg;
  assign seq_state     = state_reg;
  assign attempts_used = attempts_reg;

  // ==================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_crank_after_preheat: assert property ( // R1
    $rose(relays.crank) |-> $past(state_reg) == engine_start_pkg::ST_PREHEAT &&
      $past(elapsed_reg) >= $past(settings.heater_plug_duration))
    else $error("starter engaged without finished preheat");

  a_glow_until_released: assert property ( // R2
    $fell(relays.glow_plug) |-> !relays.crank)
    else $error("glow plug dropped while starter engaged");

  a_manual_no_glow: assert property ( // R3
    (state_reg == engine_start_pkg::ST_STOPPED && !settings.seq_enable)
      |=> !relays.glow_plug && !relays.crank)
    else $error("glow or crank from stop without sequencing");

  a_fuel_after_lag: assert property ( // R4
    (relays.fuel && state_reg == engine_start_pkg::ST_CRANK)
      |-> elapsed_reg >= $past(settings.fuel_valve_lag))
    else $error("fuel relay energized before lag");

  a_crank_time_limit: assert property ( // R5
    (state_reg == engine_start_pkg::ST_CRANK && run_reg && !at_cutout &&
     elapsed_reg >= settings.crank_time)
      |=> state_reg != engine_start_pkg::ST_CRANK &&
          attempts_reg == $past(attempts_reg) + `REPEAT_W'(1))
    else $error("crank time expired without release");

  a_manual_to_rated: assert property ( // R6
    (state_reg == engine_start_pkg::ST_STOPPED && run_reg && !settings.seq_enable)
      |=> state_reg == engine_start_pkg::ST_RATED ##0 relays.rated && !relays.crank)
    else $error("unsequenced start did not go straight to rated");

  a_cutout_release: assert property ( // R7
    (state_reg == engine_start_pkg::ST_CRANK && run_reg && at_cutout)
      |=> !relays.crank && relays.fuel)
    else $error("starter held above cutout speed");

  a_retry_wait: assert property ( // R8
    (state_reg == engine_start_pkg::ST_REST && run_reg &&
     elapsed_reg < settings.retry_time) |=> state_reg == engine_start_pkg::ST_REST)
    else $error("retry interval cut short");

  a_fail_count: assert property ( // R9
    $rose(relays.crank_fail) |->
      attempts_reg == $past(settings.crank_repeats) + `REPEAT_W'(1))
    else $error("failure raised at wrong attempt count");

  a_fail_action: assert property ( // R10
    relays.crank_fail |-> relays.fail_action == $past(settings.fail_action))
    else $error("fail action code does not match setting");

  a_no_speed_abort: assert property ( // R11
    (state_reg == engine_start_pkg::ST_CRANK && run_reg && !at_cutout && !spd_reg &&
     elapsed_reg >= settings.no_speed_time) |=> !relays.crank)
    else $error("crank continued without speed signal");

  a_idle_threshold: assert property ( // R14
    $rose(state_reg == engine_start_pkg::ST_IDLE) |-> $past(at_idle))
    else $error("idle hold began below 90 percent");

  a_rated_after_hold: assert property ( // R13
    (state_reg == engine_start_pkg::ST_IDLE && run_reg &&
     elapsed_reg < settings.idle_time) |=> !relays.rated)
    else $error("rated relay before idle time elapsed");

  a_attempt_clear: assert property ( // R18
    (state_reg == engine_start_pkg::ST_STOPPED && run_reg) |=> attempts_reg == '0)
    else $error("attempt count not cleared on start");

  a_spinup_below_idle: assert property ( // R12
    (state_reg == engine_start_pkg::ST_SPINUP && run_reg && !at_idle)
      |=> state_reg == engine_start_pkg::ST_SPINUP)
    else $error("idle hold entered below idle threshold");

  a_stopped_all_off: assert property ( // R17
    (state_reg == engine_start_pkg::ST_STOPPED) |-> relays == '0)
    else $error("relay output active while stopped");

  c_no_speed_abort: cover property (
    state_reg == engine_start_pkg::ST_CRANK && !spd_reg && !at_cutout &&
    elapsed_reg >= settings.no_speed_time && elapsed_reg < settings.crank_time);

  c_sequenced_rated: cover property (
    state_reg == engine_start_pkg::ST_IDLE ##1 state_reg == engine_start_pkg::ST_RATED);
  c_retry_taken: cover property (
    state_reg == engine_start_pkg::ST_REST ##1 state_reg == engine_start_pkg::ST_PREHEAT);
  c_crank_failed: cover property ($rose(relays.crank_fail));
  c_manual_start: cover property (
    state_reg == engine_start_pkg::ST_STOPPED && run_reg && !settings.seq_enable);

endmodule

// *** verif/engine_model.sv ***
// behavioural engine, starter and speed pickup facing the sequencer relays
// assumes the relay struct on ref_clk; mode picks how the engine behaves:
// 0 dead, 1 turns on the starter but never fires, 2 fires and runs at speed,
// 3 fires but settles just under the idle threshold
`timescale 1ns/1ps
`include "engine_start_defs.svh"

module engine_model (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire engine_start_pkg::relays_t relays,
  input  wire logic [1:0]                mode,
  output logic                           speed_detect,
  output logic [`RPM_W-1:0]              engine_rpm
);
  logic running_reg;
  logic running_next;

  // ==================================================================
  // combustion: needs starter and fuel together, dies when fuel drops
  always_comb begin
    running_next = running_reg;
    if (!relays.fuel) begin
      running_next = 1'b0;
    end else if (relays.crank && mode[1]) begin
      running_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      running_reg <= 1'b0;
    end else begin
      running_reg <= running_next;
    end
  end

  // ==================================================================
  // speed pickup; cranking speed is far below the default cutout setting
  always_comb begin
    engine_rpm = 13'h0000;
    if (running_reg) begin
      engine_rpm = (mode == 2'h3) ? 13'h0437 : 13'h05DC;
    end else if ((relays.crank || relays.glow_plug) && mode != 2'h0) begin
      engine_rpm = 13'h0064;
    end
    speed_detect = (engine_rpm != 13'h0000);
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench for the engine start sequencer
// assumes the sequencer with a four-clock tick and engine_model on its relays
`timescale 1ns/1ps
`include "engine_start_defs.svh"

module tb;
  logic                            ref_clk;
  logic                            rst_n;
  logic                            start_cmd;
  logic                            speed_detect;
  logic [`RPM_W-1:0]               engine_rpm;
  logic [1:0]                      mode;
  engine_start_pkg::settings_t     settings;
  engine_start_pkg::relays_t       relays;
  engine_start_pkg::seq_state_t    seq_state;
  logic [`REPEAT_W-1:0]            attempts_used;
  int                              mismatches;
  int                              n_compared;
  int                              cyc;

  engine_start_sequencer #(.TICK_DIV(4)) engine_start_sequencer_inst (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .start_cmd     (start_cmd),
    .speed_detect  (speed_detect),
    .engine_rpm    (engine_rpm),
    .settings      (settings),
    .relays        (relays),
    .seq_state     (seq_state),
    .attempts_used (attempts_used)
  );

  engine_model engine_model_inst (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .relays       (relays),
    .mode         (mode),
    .speed_detect (speed_detect),
    .engine_rpm   (engine_rpm)
  );

  // ==================================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    mismatches++;
    results();
  end

  // ==================================================================
  // helpers
  function automatic logic [7:0] rl(input logic g, input logic c, input logic f,
                                    input logic r, input logic cf, input logic [2:0] a);
    return {g, c, f, r, cf, a};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_state(input engine_start_pkg::seq_state_t s, input int max);
    cyc = 0;
    while (seq_state !== s && cyc < max) begin
      @(negedge ref_clk);
      cyc++;
    end
    check(32'(seq_state), 32'(s), "state reached");
  endtask

  // cycles spent in the present state
  task automatic dwell();
    engine_start_pkg::seq_state_t s;
    s = seq_state;
    cyc = 0;
    while (seq_state === s && cyc < 5000) begin
      @(negedge ref_clk);
      cyc++;
    end
  endtask

  // a span of n ticks of four clocks, allowing for tick phase
  task automatic check_span(input int n, input string what);
    check(32'(cyc >= 4 * n - 4 && cyc <= 4 * n + 2), 32'h1, what);
  endtask

  task automatic setup(input logic en, input logic [4:0] rep, input logic [2:0] act);
    settings.seq_enable           = en;
    settings.heater_plug_duration = 14'h0002;
    settings.fuel_valve_lag       = 14'h0001;
    settings.crank_time           = 14'h0003;
    settings.cutout_rpm           = `DEF_CUTOUT;
    settings.retry_time           = 14'h0002;
    settings.crank_repeats        = rep;
    settings.fail_action          = act;
    settings.no_speed_time        = 14'h0001;
    settings.idle_rpm             = `DEF_IDLE_RPM;
    settings.idle_time            = 14'h0002;
  endtask

  task automatic stop();
    start_cmd = 1'b0;
    wait_state(engine_start_pkg::ST_STOPPED, 10);
    check(32'(relays), 32'h0, "relays after stop");
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==================================================================
  // main sequence, inputs change on the falling edge
  initial begin
    start_cmd = 1'b0;
    mode      = 2'h2;
    rst_n     = 1'b0;
    setup(1'b0, 5'h01, 3'h5);
    repeat (4) @(negedge ref_clk);
    check(32'(relays), 32'h0, "reset relays");
    check(32'(seq_state), 32'(engine_start_pkg::ST_STOPPED), "reset state");
    rst_n = 1'b1;
    // sequencing off: straight to rated
    start_cmd = 1'b1;
    wait_state(engine_start_pkg::ST_RATED, 10);
    check(32'(relays), 32'(rl(0, 0, 1, 1, 0, 3'h0)), "direct rated");
    stop();
    // full start that fires on the first attempt
    settings.seq_enable = 1'b1;
    start_cmd = 1'b1;
    wait_state(engine_start_pkg::ST_PREHEAT, 10);
    check(32'(relays), 32'(rl(1, 0, 0, 0, 0, 3'h0)), "preheat");
    dwell();
    check_span(2, "preheat span");
    check(32'(seq_state), 32'(engine_start_pkg::ST_CRANK), "crank after preheat");
    check(32'(relays), 32'(rl(1, 1, 0, 0, 0, 3'h0)), "crank before fuel");
    cyc = 0;
    while (relays.fuel !== 1'b1 && cyc < 8) begin
      @(negedge ref_clk);
      cyc++;
    end
    check(32'(relays), 32'(rl(1, 1, 1, 0, 0, 3'h0)), "fuel after lag");
    wait_state(engine_start_pkg::ST_IDLE, 10);
    check(32'(relays), 32'(rl(0, 0, 1, 0, 0, 3'h0)), "starter cut out");
    dwell();
    check_span(2, "idle span");
    check(32'(seq_state), 32'(engine_start_pkg::ST_RATED), "rated state");
    check(32'(relays), 32'(rl(0, 0, 1, 1, 0, 3'h0)), "rated relay");
    check(32'(attempts_used), 32'h0, "no failed attempt");
    stop();
    // speed one rpm-step under 90 percent, then setpoint lowered live
    mode = 2'h3;
    start_cmd = 1'b1;
    wait_state(engine_start_pkg::ST_SPINUP, 60);
    repeat (20) @(negedge ref_clk);
    check(32'(seq_state), 32'(engine_start_pkg::ST_SPINUP), "held under idle");
    settings.idle_rpm = 13'h04AE;
    wait_state(engine_start_pkg::ST_IDLE, 4);
    stop();
    // dead engine, no repeats: failure action codes 1 to 6
    mode = 2'h0;
    for (int a = 1; a <= 6; a++) begin
      setup(1'b1, 5'h00, 3'(a));
      start_cmd = 1'b1;
      wait_state(engine_start_pkg::ST_CRANK, 30);
      dwell();
      check_span(1, "no speed abort");
      wait_state(engine_start_pkg::ST_FAILED, 60);
      check(32'(relays), 32'(rl(0, 0, 0, 0, 1, 3'(a))), "fail action");
      check(32'(attempts_used), 32'h1, "attempts this start");
      repeat (10) @(negedge ref_clk);
      check(32'(seq_state), 32'(engine_start_pkg::ST_FAILED), "failure latched");
      stop();
    end
    // turns but never fires: crank time expiry, retry, second attempt
    mode = 2'h1;
    setup(1'b1, 5'h01, 3'h5);
    start_cmd = 1'b1;
    wait_state(engine_start_pkg::ST_CRANK, 30);
    dwell();
    check_span(3, "crank span");
    check(32'(seq_state), 32'(engine_start_pkg::ST_REST), "rest after expiry");
    check(32'(relays), 32'h0, "relays in rest");
    check(32'(attempts_used), 32'h1, "one attempt used");
    dwell();
    check_span(2, "retry span");
    check(32'(seq_state), 32'(engine_start_pkg::ST_PREHEAT), "retry preheat");
    wait_state(engine_start_pkg::ST_FAILED, 60);
    check(32'(attempts_used), 32'h2, "repeats plus one");
    check(32'(relays), 32'(rl(0, 0, 0, 0, 1, 3'h5)), "default action");
    stop();
    results();
  end
endmodule
